// File: gtmr_params.svh
`ifndef GTMR_PARAMS_SVH
`define GTMR_PARAMS_SVH

// ==========================================================
// Instances and register map
`define GTMR_NUM 3
`define GTMR_ADDR_W 8
`define GTMR_OFS_CTRL 4'h0
`define GTMR_OFS_GCON 4'h4
`define GTMR_OFS_LOW 4'h8
`define GTMR_OFS_HIGH 4'hc
`define GTMR_ADDR_FLAGS 8'h30
`define GTMR_TSEL_NONE 2'h3
`define GTMR_FLG_OVF_LSB 0
`define GTMR_FLG_GEV_LSB 4

// ==========================================================
// Reset values and masks
`define GTMR_CTRL_RST 8'h00
`define GTMR_GCON_RST 8'h00
`define GTMR_CNT_RST 16'h0000
`define GTMR_CNT_MAX 16'hffff
`define GTMR_CNT_ONE 16'h0001
`define GTMR_CTRL_WMASK 8'hfd

// ==========================================================
// Control register fields
`define GTMR_CS 7:6
`define GTMR_PS 5:4
`define GTMR_SECONDARY_OSCILLATOR 3
`define GTMR_SYNC 2
`define GTMR_ON 0
`define GTMR_CS_LFOSC 2'b11
`define GTMR_CS_PIN 2'b10
`define GTMR_CS_SYS 2'b01
`define GTMR_CS_INSTR 2'b00
`define GTMR_PS_8 2'b11
`define GTMR_PS_4 2'b10
`define GTMR_PS_2 2'b01
`define GTMR_MASK_8 3'h7
`define GTMR_MASK_4 3'h3
`define GTMR_MASK_2 3'h1
`define GTMR_MASK_1 3'h0
`define GTMR_DIV4_LAST 2'h3

// ==========================================================
// Gate control register fields
`define GTMR_GE 7
`define GTMR_POL 6
`define GTMR_GTM 5
`define GTMR_SPM 4
`define GTMR_GO 3
`define GTMR_GVAL 2
`define GTMR_GSS 1:0
`define GTMR_GSS_CMP2 2'b11
`define GTMR_GSS_CMP1 2'b10
`define GTMR_GSS_TMR0 2'b01
`define GTMR_GSS_PIN 2'b00

`endif

// File: gtmr_pkg.sv
`default_nettype none
package gtmr_pkg;

  typedef logic [7:0] gtmr_byte_t;

  typedef enum logic [2:0]
  {
    SP_IDLE = 3'b001,
    SP_ARMED = 3'b010,
    SP_OPEN = 3'b100
  } gtmr_sp_state_t;

endpackage
`default_nettype wire

// File: gtmr_top.sv
// Summary of operation
// - Clock source 11 low-freq osc, 10 pin/secondary osc, 01 sysclk, 00 sysclk/4.
// - Source 10 counts external clock edges, or secondary osc when requested.
// - Prescale 11 divides by 8, 10 by 4, 01 by 2, 00 by 1.
// - Pin or osc source is synchronised unless the bypass bit is set.
// - Internal sources ignore the bypass bit and get no extra sync.
// - Timer on enables counting; off stops it and clears toggle flop.
// - Gate enable makes counting follow gate; else counts freely.
// - Polarity 1 counts while gate high, 0 while gate low.
// - Toggle mode flips gate flop on source rising edge; else cleared.
// - Single-pulse mode takes control of the counting gate.
// - Acquire status reads 1 while armed, hardware clears at completion.
// - Clearing single-pulse mode also clears acquire status.
// - Gate value bit shows latched gate level, whatever gate enable.
// - Gate source 11 cmp2, 10 cmp1, 01 timer0 overflow, 00 pin.
// - Low count byte holds counter bits 7..0, read and write.
// - High count byte holds counter bits 15..8, read and write.
// - Three identical timer instances with full register sets.
// - Counter rolls from ffff to 0000 and sets overflow flag.
// - Falling edge of gate value sets gate event flag always.
// - Armed pulse counts from next active edge to trailing edge only.
// - Timer0 overflow pulse feeds the gate as a rising pulse.
`timescale 1ns/1ps
`default_nettype none
`include "gtmr_params.svh"

module gtmr_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`GTMR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lfosc_clk,
  input wire logic secondary_oscillator_clk,
  input wire logic [`GTMR_NUM-1:0] ext_clk_in,
  input wire logic [`GTMR_NUM-1:0] gate_pin,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic tmr0_ovf,
  output logic [`GTMR_NUM-1:0] overflow_pulse
);

  // ==========================================================
  // Helpers
  function automatic logic [2:0] presc_mask(input logic [1:0] ps);
    case (ps)
      `GTMR_PS_8: presc_mask = `GTMR_MASK_8;
      `GTMR_PS_4: presc_mask = `GTMR_MASK_4;
      `GTMR_PS_2: presc_mask = `GTMR_MASK_2;
      default: presc_mask = `GTMR_MASK_1;
    endcase
  endfunction

  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  // ==========================================================
  // APB slave
  logic access, wr, hit_t, hit_flags;
  logic [1:0] tsel;
  logic [3:0] ofs;
  logic [31:0] next_prdata;

  gtmr_pkg::gtmr_byte_t ctrl [`GTMR_NUM];
  gtmr_pkg::gtmr_byte_t gcon [`GTMR_NUM];
  logic [15:0] cnt [`GTMR_NUM];
  logic gval [`GTMR_NUM];
  logic [`GTMR_NUM-1:0] ovf_f, gev_f;
  wire [`GTMR_NUM-1:0] ovf_ev, gev_ev;

  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign tsel = paddr[5:4];
  assign ofs = paddr[3:0];
  assign hit_t = (paddr[7:6] == 2'b00) & (tsel != `GTMR_TSEL_NONE)
    & (ofs[1:0] == 2'b00);
  assign hit_flags = (paddr == `GTMR_ADDR_FLAGS);

  // One wait state keeps read data registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else if (clk_en)
      pready <= psel & penable & ~pready;
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_flags)
    begin
      next_prdata[`GTMR_FLG_OVF_LSB +: `GTMR_NUM] = ovf_f;
      next_prdata[`GTMR_FLG_GEV_LSB +: `GTMR_NUM] = gev_f;
    end
    else if (hit_t)
    begin
      case (ofs)
        `GTMR_OFS_CTRL: next_prdata[7:0] = ctrl[tsel];
        `GTMR_OFS_GCON:
        begin
          next_prdata[7:0] = gcon[tsel];
          next_prdata[`GTMR_GVAL] = gval[tsel];
        end
        `GTMR_OFS_LOW: next_prdata[7:0] = cnt[tsel][7:0];
        `GTMR_OFS_HIGH: next_prdata[7:0] = cnt[tsel][15:8];
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      if (psel & penable & ~pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= ~(hit_t | hit_flags);
      end
    end
  end

  // ==========================================================
  // Shared clock sources
  logic [1:0] div4;
  logic lf_prev, lf_edge;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div4 <= 2'h0;
      lf_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      div4 <= 2'(div4 + 2'h1);
      lf_prev <= lfosc_clk;
    end
  end

  // Internal oscillator needs no extra sync stage
  assign lf_edge = rise(lfosc_clk, lf_prev);

  // ==========================================================
  // Flags, set wins over a same-cycle clear
  logic [`GTMR_NUM-1:0] ovf_clr, gev_clr;

  assign ovf_clr = (wr & hit_flags)
    ? pwdata[`GTMR_FLG_OVF_LSB +: `GTMR_NUM] : '0;
  assign gev_clr = (wr & hit_flags)
    ? pwdata[`GTMR_FLG_GEV_LSB +: `GTMR_NUM] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_f <= '0;
      gev_f <= '0;
      overflow_pulse <= '0;
    end
    else if (clk_en)
    begin
      ovf_f <= ovf_ev | (ovf_f & ~ovf_clr);
      gev_f <= gev_ev | (gev_f & ~gev_clr);
      overflow_pulse <= ovf_ev;
    end
  end

  // ==========================================================
  // Timer instances
  genvar k;
  generate
    for (k = 0; k < `GTMR_NUM; k++)
    begin : g_tm
      logic sel_k, wr_ctrl, wr_gcon, wr_low, wr_high;
      logic src_in, s1, s2, s3, raw_prev, pin_edge, tick, ptick;
      logic [2:0] pcnt;
      logic gsrc, gsrc_prev, tff, g, gp, gp_prev, eff, gval_prev;
      logic go_done, count_en, inc;
      gtmr_pkg::gtmr_sp_state_t sp, next_sp;

      assign sel_k = wr & hit_t & (tsel == 2'(k));
      assign wr_ctrl = sel_k & (ofs == `GTMR_OFS_CTRL);
      assign wr_gcon = sel_k & (ofs == `GTMR_OFS_GCON);
      assign wr_low = sel_k & (ofs == `GTMR_OFS_LOW);
      assign wr_high = sel_k & (ofs == `GTMR_OFS_HIGH);
      // Registers
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ctrl[k] <= `GTMR_CTRL_RST;
        else if (clk_en & wr_ctrl)
          ctrl[k] <= pwdata[7:0] & `GTMR_CTRL_WMASK;
      end

      assign go_done = (sp == gtmr_pkg::SP_OPEN) & ~gp;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          gcon[k] <= `GTMR_GCON_RST;
        else if (clk_en)
        begin
          if (wr_gcon)
          begin
            gcon[k] <= pwdata[7:0];
            gcon[k][`GTMR_GVAL] <= 1'b0;
            if (!pwdata[`GTMR_SPM])
              gcon[k][`GTMR_GO] <= 1'b0;
          end
          else if (!gcon[k][`GTMR_SPM] | go_done)
            gcon[k][`GTMR_GO] <= 1'b0;
        end
      end
      // Clock selection; a pin source goes through two stages
      // unless bypassed, trading latency for metastability margin
      assign src_in = ctrl[k][`GTMR_SECONDARY_OSCILLATOR]
        ? secondary_oscillator_clk : ext_clk_in[k];

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          raw_prev <= 1'b0;
        end
        else if (clk_en)
        begin
          s1 <= src_in;
          s2 <= s1;
          s3 <= s2;
          raw_prev <= src_in;
        end
      end

      assign pin_edge = ctrl[k][`GTMR_SYNC]
        ? rise(src_in, raw_prev) : rise(s2, s3);

      always_comb
      begin
        case (ctrl[k][`GTMR_CS])
          `GTMR_CS_LFOSC: tick = lf_edge;
          `GTMR_CS_PIN: tick = pin_edge;
          `GTMR_CS_SYS: tick = 1'b1;
          `GTMR_CS_INSTR: tick = (div4 == `GTMR_DIV4_LAST);
          default: tick = 1'b0;
        endcase
      end
      // Prescaler
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pcnt <= 3'h0;
        else if (clk_en)
        begin
          if (!ctrl[k][`GTMR_ON])
            pcnt <= 3'h0;
          else if (tick)
            pcnt <= 3'(pcnt + 3'h1);
        end
      end

      assign ptick = tick & ((pcnt & presc_mask(ctrl[k][`GTMR_PS]))
        == presc_mask(ctrl[k][`GTMR_PS]));
      // Gate path
      always_comb
      begin
        case (gcon[k][`GTMR_GSS])
          `GTMR_GSS_CMP2: gsrc = cmp2_out;
          `GTMR_GSS_CMP1: gsrc = cmp1_out;
          `GTMR_GSS_TMR0: gsrc = tmr0_ovf;
          `GTMR_GSS_PIN: gsrc = gate_pin[k];
          default: gsrc = 1'b0;
        endcase
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          gsrc_prev <= 1'b0;
          tff <= 1'b0;
        end
        else if (clk_en)
        begin
          gsrc_prev <= gsrc;
          if (!ctrl[k][`GTMR_ON] | !gcon[k][`GTMR_GTM])
            tff <= 1'b0;
          else if (rise(gsrc, gsrc_prev))
            tff <= ~tff;
        end
      end

      assign g = gcon[k][`GTMR_GTM] ? tff : gsrc;
      assign gp = gcon[k][`GTMR_POL] ? g : ~g;
      // Single-pulse acquisition
      always_comb
      begin
        next_sp = sp;
        case (sp)
          gtmr_pkg::SP_IDLE:
            if (gcon[k][`GTMR_SPM] & gcon[k][`GTMR_GO])
              next_sp = gtmr_pkg::SP_ARMED;
          gtmr_pkg::SP_ARMED:
            if (rise(gp, gp_prev))
              next_sp = gtmr_pkg::SP_OPEN;
          gtmr_pkg::SP_OPEN:
            if (!gp)
              next_sp = gtmr_pkg::SP_IDLE;
          default: next_sp = gtmr_pkg::SP_IDLE;
        endcase
        if (!gcon[k][`GTMR_SPM] | !gcon[k][`GTMR_GO])
          next_sp = gtmr_pkg::SP_IDLE;
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sp <= gtmr_pkg::SP_IDLE;
          gp_prev <= 1'b0;
        end
        else if (clk_en)
        begin
          sp <= next_sp;
          gp_prev <= gp;
        end
      end

      assign eff = gcon[k][`GTMR_SPM]
        ? ((sp == gtmr_pkg::SP_OPEN) & gp) : gp;
      // Gate value and gate event
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          gval[k] <= 1'b0;
          gval_prev <= 1'b0;
        end
        else if (clk_en)
        begin
          gval[k] <= eff;
          gval_prev <= gval[k];
        end
      end

      assign gev_ev[k] = clk_en & gval_prev & ~gval[k];
      // Counter; a software write beats the increment
      assign count_en = ctrl[k][`GTMR_ON]
        & (~gcon[k][`GTMR_GE] | gval[k]);
      assign inc = count_en & ptick & ~wr_low & ~wr_high;
      assign ovf_ev[k] = clk_en & inc & (cnt[k] == `GTMR_CNT_MAX);

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cnt[k] <= `GTMR_CNT_RST;
        else if (clk_en)
        begin
          if (wr_low)
            cnt[k][7:0] <= pwdata[7:0];
          else if (wr_high)
            cnt[k][15:8] <= pwdata[7:0];
          else if (inc)
            cnt[k] <= 16'(cnt[k] + `GTMR_CNT_ONE);
        end
      end
    end
  endgenerate

endmodule // gtmr_top

`default_nettype wire

// File: gtmr_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtmr_params.svh"
// ==========================================================
// Port checker
module gtmr_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`GTMR_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`GTMR_NUM-1:0] overflow_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_done;
  assign rd_done = pready && !pwrite;
  a_answer_follows: assert property (
    psel && penable && !pready && clk_en |=> pready)
    else $error("no answer one cycle after access");
  a_answer_single: assert property (
    pready && clk_en |=> !pready)
    else $error("answer held longer than one cycle");
  a_answer_cause: assert property (
    pready |-> $past(psel && penable))
    else $error("answer without access phase");
  a_idle_quiet: assert property (
    !$past(psel) |-> !pready)
    else $error("answer while idle");
  a_read_byte: assert property (
    rd_done |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_ctrl_gap: assert property (
    rd_done && paddr[3:0] == 4'h0 && paddr < 8'h30 |-> !prdata[1])
    else $error("unused control bit reads one");
  a_timer_mapped: assert property (
    pready && paddr < 8'h30 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on timer register");
  a_hole_error: assert property (
    pready && paddr > 8'h33 |-> pslverr)
    else $error("no error on unmapped address");
  a_ovf_once: assert property (
    overflow_pulse != 3'h0 |=>
      (overflow_pulse & $past(overflow_pulse)) == 3'h0)
    else $error("overflow pulse wider than one cycle");
endmodule // gtmr_chk

bind gtmr_top gtmr_chk u_chk
(
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .overflow_pulse(overflow_pulse)
);
`default_nettype wire

// File: gtmr_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side sources
module gtmr_partner
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_run,
  input wire logic ovf_req,
  output logic lfosc_clk,
  output logic secondary_oscillator_clk,
  output logic [2:0] ext_clk_in,
  output logic tmr0_ovf
);
  logic [3:0] div;
  logic req_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div <= 4'h0;
    else
      div <= div + 4'h1;
  end
  // One-cycle pulse per request edge, like a wrapping 8-bit timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q <= 1'b0;
      tmr0_ovf <= 1'b0;
    end
    else
    begin
      req_q <= ovf_req;
      tmr0_ovf <= ovf_req && !req_q;
    end
  end
  assign lfosc_clk = div[3];
  assign secondary_oscillator_clk = div[2];
  // Pin clock stands still low outside counting tests
  assign ext_clk_in = ext_run ? {3{div[1]}} : 3'h0;
endmodule // gtmr_partner
`default_nettype wire

// File: test_gated_sixteen_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtmr_params.svh"
// ==========================================================
// Bench
module test_gated_sixteen_bit_timer;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, v1;
  logic [31:0] pwdata, prdata, rv;
  logic [2:0] gate_pin, ext_clk_in, overflow_pulse;
  logic lfosc_clk, secondary_oscillator_clk, cmp1_out, cmp2_out, tmr0_ovf, ovf_req, ext_run;
  logic clk_en;
  int n_errors, checks_done, cyc, n_ovf, st, k;
  logic [7:0] src [7] = '{8'h40, 8'h44, 8'h00, 8'hc0, 8'h88, 8'h80, 8'h84};
  int per [7] = '{1, 1, 4, 16, 8, 4, 4};
  gtmr_top dut
  (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lfosc_clk(lfosc_clk), .secondary_oscillator_clk(secondary_oscillator_clk), .ext_clk_in(ext_clk_in),
    .gate_pin(gate_pin), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
    .tmr0_ovf(tmr0_ovf), .overflow_pulse(overflow_pulse)
  );
  gtmr_partner u_far
  (
    .pclk(pclk), .presetn(presetn), .ext_run(ext_run), .ovf_req(ovf_req),
    .lfosc_clk(lfosc_clk), .secondary_oscillator_clk(secondary_oscillator_clk), .ext_clk_in(ext_clk_in),
    .tmr0_ovf(tmr0_ovf)
  );
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    n_ovf <= n_ovf + $countones(overflow_pulse);
  end
  // ==========================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] ad(input int t, input logic [3:0] o);
    return {2'b00, 2'(t), o};
  endfunction
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    st = cyc;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Two low-byte reads exactly 128 cycles apart, so any divider fits
  task automatic meas(input int t, input int dv);
    int s;
    xfer(1'b0, ad(t, `GTMR_OFS_LOW), 8'h00);
    v1 = rv[7:0];
    s = st;
    while (cyc - s < 127)
      @(posedge pclk);
    xfer(1'b0, ad(t, `GTMR_OFS_LOW), 8'h00);
    check("ticks", 32'(8'(rv[7:0] - v1)), 32'(dv == 0 ? 0 : 128 / dv));
  endtask
  task automatic drive_src(input int g, input logic v);
    case (g)
      0: gate_pin[0] <= v;
      1: ovf_req <= v;
      2: cmp1_out <= v;
      default: cmp2_out <= v;
    endcase
  endtask
  task automatic pulse(input int g, input int w);
    drive_src(g, 1'b1);
    repeat (w) @(posedge pclk);
    drive_src(g, 1'b0);
    repeat (12) @(posedge pclk);
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    #(30000 * 20);
    n_errors++;
    close_out();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, cmp1_out, cmp2_out} = 6'h00;
    clk_en = 1'b1;
    {ovf_req, ext_run, gate_pin, paddr, pwdata} = '0;
    {n_errors, checks_done, cyc, n_ovf} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 13; i++)
    begin
      xfer(1'b0, 8'(i * 4), 8'h00);
      check("reset", i % 4 == 1 ? rv & 32'hfb : rv, 32'h0);
    end
    xfer(1'b1, 8'h34, 8'hff);
    xfer(1'b0, 8'h34, 8'h00);
    check("hole", {rv[30:0], er}, 32'h1);
    xfer(1'b1, ad(2, `GTMR_OFS_CTRL), 8'hfe);
    xfer(1'b0, ad(2, `GTMR_OFS_CTRL), 8'h00);
    check("ctrl_rw", rv, 32'hfc);
    ext_run <= 1'b1;
    for (int j = 0; j < 28; j++)
    begin
      k = j % 3;
      xfer(1'b1, ad(k, `GTMR_OFS_CTRL), src[j / 4] | 8'(j % 4 << 4) | 8'h01);
      meas(k, per[j / 4] << (j % 4));
      xfer(1'b1, ad(k, `GTMR_OFS_CTRL), 8'h00);
    end
    ext_run <= 1'b0;
    meas(2, 0);
    xfer(1'b1, ad(0, `GTMR_OFS_CTRL), 8'h41);
    xfer(1'b1, ad(0, `GTMR_OFS_GCON), 8'hc0);
    meas(0, 0);
    gate_pin[0] <= 1'b1;
    meas(0, 1);
    xfer(1'b1, ad(0, `GTMR_OFS_GCON), 8'h80);
    meas(0, 0);
    gate_pin[0] <= 1'b0;
    xfer(1'b1, 8'h30, 8'h77);
    for (int g = 0; g < 4; g++)
    begin
      xfer(1'b1, ad(0, `GTMR_OFS_GCON), 8'he0 | 8'(g));
      pulse(g, 3);
      meas(0, 1);
      xfer(1'b0, ad(0, `GTMR_OFS_GCON), 8'h00);
      check("gval", rv, 32'he4 | 32'(g));
      pulse(g, 3);
      meas(0, 0);
    end
    xfer(1'b0, 8'h30, 8'h00);
    check("gate_evt", rv, 32'h10);
    xfer(1'b1, 8'h30, 8'h10);
    xfer(1'b1, ad(0, `GTMR_OFS_GCON), 8'h40);
    pulse(0, 3);
    xfer(1'b0, 8'h30, 8'h00);
    check("evt_no_ge", rv, 32'h10);
    xfer(1'b1, 8'h30, 8'h10);
    xfer(1'b1, ad(0, `GTMR_OFS_GCON), 8'hd8);
    xfer(1'b0, ad(0, `GTMR_OFS_GCON), 8'h00);
    check("armed", rv, 32'hd8);
    for (int p = 0; p < 2; p++)
    begin
      xfer(1'b0, ad(0, `GTMR_OFS_LOW), 8'h00);
      v1 = rv[7:0];
      pulse(0, 10);
      xfer(1'b0, ad(0, `GTMR_OFS_LOW), 8'h00);
      check("sp_count", 32'(rv[7:0] != v1), 32'(p == 0));
      xfer(1'b0, ad(0, `GTMR_OFS_GCON), 8'h00);
      check("sp_done", rv, 32'hd0);
    end
    xfer(1'b1, ad(0, `GTMR_OFS_GCON), 8'hd8);
    xfer(1'b1, ad(0, `GTMR_OFS_GCON), 8'hc8);
    xfer(1'b0, ad(0, `GTMR_OFS_GCON), 8'h00);
    check("spm_off", rv, 32'hc0);
    xfer(1'b1, ad(0, `GTMR_OFS_CTRL), 8'h00);
    xfer(1'b1, 8'h30, 8'h77);
    xfer(1'b1, ad(1, `GTMR_OFS_HIGH), 8'hff);
    xfer(1'b1, ad(1, `GTMR_OFS_LOW), 8'hf0);
    xfer(1'b1, ad(1, `GTMR_OFS_CTRL), 8'h41);
    repeat (30) @(posedge pclk);
    xfer(1'b1, ad(1, `GTMR_OFS_CTRL), 8'h00);
    xfer(1'b0, ad(1, `GTMR_OFS_HIGH), 8'h00);
    check("roll_high", rv, 32'h0);
    xfer(1'b0, 8'h30, 8'h00);
    check("ovf_flag", rv, 32'h02);
    check("ovf_pulse", 32'(n_ovf), 32'h1);
    // Enable low for 64 edges: only two edges each side count
    xfer(1'b1, ad(2, `GTMR_OFS_CTRL), 8'h41);
    xfer(1'b0, ad(2, `GTMR_OFS_LOW), 8'h00);
    v1 = rv[7:0];
    clk_en <= 1'b0;
    repeat (64) @(posedge pclk);
    clk_en <= 1'b1;
    xfer(1'b0, ad(2, `GTMR_OFS_LOW), 8'h00);
    check("freeze", 32'(8'(rv[7:0] - v1)), 32'h4);
    close_out();
  end
endmodule // test_gated_sixteen_bit_timer
`default_nettype wire
